// >>> rtl/cs_pkg.sv
// Constants, carrier types and field layout for the memory chip-select decoder
package cs_pkg;

    localparam logic [7:0]  OFS_UPPER      = 8'hA0;
    localparam logic [7:0]  OFS_LOWER      = 8'hA2;
    localparam logic [7:0]  OFS_MID_BASE   = 8'hA6;
    localparam logic [7:0]  OFS_MID_SIZE   = 8'hA8;
    localparam logic [15:0] UPPER_RST      = 16'hFFFB;
    localparam logic [15:0] ZERO_WORD      = 16'h0000;
    localparam logic [5:0]  LOW_ZEROS      = 6'h00;
    localparam logic [5:0]  LOW_ONES       = 6'h3F;
    localparam int          LIMIT_LSB      = 6;
    localparam int          MID_BASE_LSB   = 9;
    localparam int          MID_SIZE_LSB   = 8;
    localparam int          MID_SIZE_BITS  = 7;
    localparam int          MID_BLOCK_LSB  = 13;
    localparam int          MID_QUART_LSB  = 11;
    localparam int          WAIT_BITS      = 2;
    localparam logic [2:0]  MODE_EXT_ZERO  = 3'h0;
    localparam logic [1:0]  WAIT_NONE      = 2'h0;
    localparam logic [1:0]  WAIT_ONE       = 2'h1;
    localparam logic [3:0]  MID_IDLE       = 4'hF;

    // Register access from the control block
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  offset;
        logic [15:0] wdata;
    } reg_access_t;

    // New bus cycle address from core or DMA
    typedef struct packed {
        logic        valid;
        logic        mem;
        logic [19:0] addr;
    } bus_cycle_t;

endpackage

// >>> rtl/cs_ready_gen.sv
// Wait-state generator for the selected region's ready mode
`timescale 1ns/1ps
module cs_ready_gen
    import cs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       start,
    input  wire logic [2:0] mode,
    input  wire logic       ext_ready,
    output logic            ready_q
);

    typedef enum {IDLE, COUNT} rdy_state_t;

    rdy_state_t            state_q, state_d;
    logic [WAIT_BITS-1:0]  cnt_q, cnt_d;
    logic                  ign_q, ign_d;
    logic                  ready_d;

    // Counter runs alongside external ready, not after it
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        ign_d   = ign_q;
        ready_d = 1'b0;
        case (state_q)
            IDLE: begin
            end
            COUNT: begin
                if (cnt_q != WAIT_NONE) begin
                    cnt_d = cnt_q - WAIT_ONE;
                end else if (ign_q || ext_ready) begin
                    ready_d = 1'b1;
                    state_d = IDLE;
                end
            end
            default: begin
                state_d = IDLE;
            end
        endcase
        if (start) begin
            state_d = COUNT;
            cnt_d   = mode[WAIT_BITS-1:0];
            ign_d   = mode[2];
            ready_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= IDLE;
            cnt_q   <= WAIT_NONE;
            ign_q   <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            ign_q   <= ign_d;
            ready_q <= ready_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence start_ignore_three;
        start && mode == 3'h7;
    endsequence

    // Ready pulse shape once the last wait has been counted
    sequence wait_then_ready;
        !ready_q ##1 ready_q ##1 !ready_q;
    endsequence

    // Ready appears one edge after the cycle that finishes the count
    ready_ignore_a: assert property (start && mode == 3'h4 ##1 !start |=> ready_q)
        else $error("ready not given at once with waits off and external ignored");
    three_waits_a: assert property (start_ignore_three ##1 !start [*4] |-> wait_then_ready)
        else $error("three wait states not counted");
    overlap_wait_a: assert property (start && mode == 3'h1 ##1 !start [*2] |->
        !ready_q ##1 ready_q == $past(ext_ready))
        else $error("external ready not overlapped with internal wait");
    ready_pulse_a: assert property (ready_q |=> !ready_q)
        else $error("ready held longer than one cycle");

endmodule

// >>> rtl/memory_chip_select_decoder.sv
// Memory chip-select decoder with region registers and ready generation
`timescale 1ns/1ps
module memory_chip_select_decoder
    import cs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire reg_access_t ctl,
    input  wire bus_cycle_t  cyc,
    input  wire logic        ext_ready,
    output logic [15:0]      rdata_q,
    output logic             upper_mem_select_b_q,
    output logic             lower_mem_select_b_q,
    output logic [3:0]       mid_mem_selects_b_q,
    output logic             cycle_ready_q
);

    logic [15:0] upper_region_limit_q, upper_region_limit_d;
    logic [15:0] lower_region_limit_q, lower_region_limit_d;
    logic [15:0] mid_region_base_q, mid_region_base_d;
    logic [15:0] mid_size_and_periph_mode_q, mid_size_and_periph_mode_d;
    logic        lower_seen_q, lower_seen_d;
    logic        mid_base_seen_q, mid_base_seen_d;
    logic        mid_size_seen_q, mid_size_seen_d;
    logic [15:0] rdata_d;
    logic        upper_b_d, lower_b_d;
    logic [3:0]  mid_b_d;
    logic        upper_hit, lower_hit, mid_hit, any_access;
    logic [1:0]  mid_quarter;
    logic [2:0]  ready_mode;
    logic [2:0]  mid_info;

    // True when the access hits the given register offset
    function automatic logic hits(input reg_access_t a, input logic [7:0] ofs);
        return (a.wr || a.rd) && a.offset == ofs;
    endfunction

    // Mid block match and quarter index from the one-hot size field
    function automatic logic [2:0] mid_decode(input logic [19:0] addr, input logic [15:0] base,
                                              input logic [15:0] size);
        logic [19:0] base20;
        logic [2:0]  res;
        base20 = {base[15:MID_BASE_LSB], 13'h0000};
        res    = 3'h0;
        for (int i = 0; i < MID_SIZE_BITS; i++) begin
            if (size[MID_SIZE_LSB + i]) begin
                res[2]   = ((addr ^ base20) >> (MID_BLOCK_LSB + i)) == 20'h00000;
                res[1:0] = addr[MID_QUART_LSB + i +: 2];
            end
        end
        return res;
    endfunction

    // Register writes and the accessed flags
    always_comb begin
        upper_region_limit_d       = upper_region_limit_q;
        lower_region_limit_d       = lower_region_limit_q;
        mid_region_base_d          = mid_region_base_q;
        mid_size_and_periph_mode_d = mid_size_and_periph_mode_q;
        lower_seen_d               = lower_seen_q || hits(ctl, OFS_LOWER);
        mid_base_seen_d            = mid_base_seen_q || hits(ctl, OFS_MID_BASE);
        mid_size_seen_d            = mid_size_seen_q || hits(ctl, OFS_MID_SIZE);
        rdata_d                    = rdata_q;
        if (ctl.wr) begin
            case (ctl.offset)
                OFS_UPPER:    upper_region_limit_d = ctl.wdata;
                OFS_LOWER:    lower_region_limit_d = ctl.wdata;
                OFS_MID_BASE: mid_region_base_d = ctl.wdata;
                OFS_MID_SIZE: mid_size_and_periph_mode_d = ctl.wdata;
                default: begin
                end
            endcase
        end
        if (ctl.rd) begin
            case (ctl.offset)
                OFS_UPPER:    rdata_d = upper_region_limit_q;
                OFS_LOWER:    rdata_d = lower_region_limit_q;
                OFS_MID_BASE: rdata_d = mid_region_base_q;
                OFS_MID_SIZE: rdata_d = mid_size_and_periph_mode_q;
                default:      rdata_d = ZERO_WORD;
            endcase
        end
    end

    // Registers; the upper limit resets to UPPER_RST, the other three registers to zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            upper_region_limit_q       <= UPPER_RST;
            lower_region_limit_q       <= ZERO_WORD;
            mid_region_base_q          <= ZERO_WORD;
            mid_size_and_periph_mode_q <= ZERO_WORD;
            lower_seen_q               <= 1'b0;
            mid_base_seen_q            <= 1'b0;
            mid_size_seen_q            <= 1'b0;
            rdata_q                    <= ZERO_WORD;
        end else begin
            upper_region_limit_q       <= upper_region_limit_d;
            lower_region_limit_q       <= lower_region_limit_d;
            mid_region_base_q          <= mid_region_base_d;
            mid_size_and_periph_mode_q <= mid_size_and_periph_mode_d;
            lower_seen_q               <= lower_seen_d;
            mid_base_seen_q            <= mid_base_seen_d;
            mid_size_seen_q            <= mid_size_seen_d;
            rdata_q                    <= rdata_d;
        end
    end

    // Address decode for the cycle being presented
    always_comb begin
        any_access  = cyc.valid && cyc.mem;
        upper_hit   = cyc.addr[19:4] >= {upper_region_limit_q[15:LIMIT_LSB], LOW_ZEROS};
        lower_hit   = lower_seen_q &&
                      cyc.addr[19:4] <= {lower_region_limit_q[15:LIMIT_LSB], LOW_ONES};
        mid_info    = mid_decode(cyc.addr, mid_region_base_q, mid_size_and_periph_mode_q);
        mid_hit     = mid_base_seen_q && mid_size_seen_q && mid_info[2];
        mid_quarter = mid_info[1:0];
        upper_b_d   = upper_mem_select_b_q;
        lower_b_d   = lower_mem_select_b_q;
        mid_b_d     = mid_mem_selects_b_q;
        ready_mode  = MODE_EXT_ZERO;
        if (cyc.valid) begin
            upper_b_d = !(any_access && upper_hit);
            lower_b_d = !(any_access && lower_hit);
            mid_b_d   = MID_IDLE;
            if (any_access && mid_hit) begin
                mid_b_d[mid_quarter] = 1'b0;
            end
        end
        // Ready mode of the selected region
        if (any_access && upper_hit) begin
            ready_mode = upper_region_limit_q[2:0];
        end else if (any_access && lower_hit) begin
            ready_mode = lower_region_limit_q[2:0];
        end else if (any_access && mid_hit) begin
            ready_mode = mid_region_base_q[2:0];
        end
    end

    // Active-low selects, all high in reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            upper_mem_select_b_q <= 1'b1;
            lower_mem_select_b_q <= 1'b1;
            mid_mem_selects_b_q  <= MID_IDLE;
        end else begin
            upper_mem_select_b_q <= upper_b_d;
            lower_mem_select_b_q <= lower_b_d;
            mid_mem_selects_b_q  <= mid_b_d;
        end
    end

    // Wait states for the decoded region
    cs_ready_gen u_ready (
        .clk       (clk),
        .rst_b     (rst_b),
        .start     (cyc.valid),
        .mode      (ready_mode),
        .ext_ready (ext_ready),
        .ready_q   (cycle_ready_q)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Reset values and register contents
    reset_selects_a: assert property (@(posedge clk) disable iff (1'b0) !rst_b |=>
        upper_mem_select_b_q && lower_mem_select_b_q && mid_mem_selects_b_q == MID_IDLE)
        else $error("select active during reset");
    upper_after_reset_a: assert property ($past(!rst_b) |-> upper_region_limit_q == UPPER_RST)
        else $error("upper limit not at reset value");
    upper_decode_a: assert property (cyc.valid && cyc.mem && cyc.addr[19:4] >=
        {upper_region_limit_q[15:6], 6'h00} |=> !upper_mem_select_b_q)
        else $error("upper select missing");
    lower_decode_a: assert property (cyc.valid && cyc.mem && lower_seen_q && cyc.addr[19:4] <=
        {lower_region_limit_q[15:6], 6'h3F} |=> !lower_mem_select_b_q)
        else $error("lower select missing");
    // Gating until the registers have been touched
    lower_gate_a: assert property (cyc.valid && !lower_seen_q |=> lower_mem_select_b_q)
        else $error("lower select before register access");
    mid_gate_a: assert property (cyc.valid && !(mid_base_seen_q && mid_size_seen_q) |=>
        mid_mem_selects_b_q == MID_IDLE)
        else $error("mid select before both registers accessed");
    // Quarter selects and hold between cycles
    mid_single_a: assert property ($onehot0(~mid_mem_selects_b_q))
        else $error("more than one mid select active");
    select_hold_a: assert property (!cyc.valid |=> $stable(mid_mem_selects_b_q) &&
        $stable(upper_mem_select_b_q) && $stable(lower_mem_select_b_q))
        else $error("select changed without a new cycle");
    mid_base_a: assert property (cyc.valid && cyc.mem && mid_base_seen_q && mid_size_seen_q &&
        mid_size_and_periph_mode_q[14:8] == 7'h01 && cyc.addr[19:13] == mid_region_base_q[15:9]
        |=> !mid_mem_selects_b_q[$past(cyc.addr[12:11])])
        else $error("mid quarter select wrong");

    // Upper cycle with no waits and external ready ignored
    sequence upper_quick_cycle;
        cyc.valid && cyc.mem && upper_hit && upper_region_limit_q[2:0] == 3'h4;
    endsequence

    // Upper region mode reaches the wait-state generator
    upper_quick_a: assert property (upper_quick_cycle ##1 !cyc.valid |=> cycle_ready_q)
        else $error("upper ready mode not applied");

    // I/O cycles never select memory
    io_idle_a: assert property (cyc.valid && !cyc.mem |=> upper_mem_select_b_q &&
        lower_mem_select_b_q && mid_mem_selects_b_q == MID_IDLE)
        else $error("memory select on an I/O cycle");

    // A hit inside the mid block drives exactly one quarter
    mid_one_quarter_a: assert property (cyc.valid && cyc.mem && mid_base_seen_q && mid_size_seen_q &&
        mid_info[2] |=> $countones(~mid_mem_selects_b_q) == 1)
        else $error("mid block hit without exactly one quarter select");

    // Top of memory always lies in the upper region
    upper_top_a: assert property (cyc.valid && cyc.mem && cyc.addr[19:4] == 16'hFFFF
        |=> !upper_mem_select_b_q)
        else $error("top of memory not selected");

    // Lowest kilobyte always lies in the lower region once enabled
    lower_base_a: assert property (cyc.valid && cyc.mem && lower_seen_q && cyc.addr[19:10] == 10'h000
        |=> !lower_mem_select_b_q)
        else $error("bottom of memory not selected");

    // Reading the upper limit returns the stored word
    read_upper_a: assert property (ctl.rd && ctl.offset == OFS_UPPER
        |=> rdata_q == $past(upper_region_limit_q))
        else $error("upper limit read back wrong");

endmodule

// >>> verif/mem_device_model.sv
// External memory device that holds the ready line low for a set delay
`timescale 1ns/1ps
module mem_device_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       strobe,
    input  wire logic [5:0] sel_b,
    input  wire logic [3:0] lat,
    output logic            ext_ready
);
    logic [3:0] cnt_d;
    logic [3:0] cnt_q;

    // Busy count loads on each new bus cycle and runs down to zero
    always_comb begin
        cnt_d = cnt_q;
        if (strobe) begin
            cnt_d = lat;
        end else if (cnt_q != 4'h0) begin
            cnt_d = cnt_q - 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Pull-up keeps ready high while no device is selected
    assign ext_ready = (cnt_q == 4'h0) || (&sel_b);
endmodule

// >>> verif/tb_memory_chip_select_decoder.sv
// Self-checking bench for the memory chip-select decoder
`timescale 1ns/1ps
module tb_memory_chip_select_decoder
    import cs_pkg::*;
;
    logic        clk;
    logic        rst_b;
    reg_access_t ctl;
    bus_cycle_t  cyc;
    logic        ext_ready;
    logic [15:0] rdata_q;
    logic [5:0]  sel_b;
    logic        cycle_ready_q;
    logic [3:0]  lat;
    logic [15:0] um, lm, mb, ms;
    logic        la, ma, sa;
    logic [31:0] rnd;
    int          mismatches, compares, cycles;

    memory_chip_select_decoder DUT (.clk(clk), .rst_b(rst_b), .ctl(ctl), .cyc(cyc), .ext_ready(ext_ready),
        .rdata_q(rdata_q), .upper_mem_select_b_q(sel_b[5]), .lower_mem_select_b_q(sel_b[4]),
        .mid_mem_selects_b_q(sel_b[3:0]), .cycle_ready_q(cycle_ready_q));
    mem_device_model mem (.clk(clk), .rst_b(rst_b), .strobe(cyc.valid), .sel_b(sel_b), .lat(lat),
        .ext_ready(ext_ready));

    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Reference decode: returns {ready mode, selects}
    function automatic logic [8:0] expect_cycle(input logic mem_c, input logic [19:0] a);
        logic [5:0]  s;
        logic [19:0] t;
        int          k;
        s = 6'h3F;
        k = 0;
        for (int i = 0; i < 7; i++) if (ms[8+i]) k = i;
        t = a >> (11 + k);
        if (mem_c && a[19:4] >= {um[15:6], 6'h00}) s[5] = 1'b0;
        if (mem_c && la && a[19:4] <= {lm[15:6], 6'h3F}) s[4] = 1'b0;
        if (mem_c && ma && sa && (a >> (13 + k)) == 20'(mb[15:9] >> k)) s[t[1:0]] = 1'b0;
        return {(!s[5] ? um[2:0] : !s[4] ? lm[2:0] : (s[3:0] != 4'hF) ? mb[2:0] : 3'h0), s};
    endfunction

    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One register read or write, shadow copy kept alongside
    task automatic reg_op(input logic w, input logic [7:0] ofs, input logic [15:0] d);
        @(posedge clk);
        ctl <= '{wr: w, rd: !w, offset: ofs, wdata: d};
        @(posedge clk);
        ctl <= '0;
        #1;
        um = (w && ofs == OFS_UPPER) ? d : um;
        lm = (w && ofs == OFS_LOWER) ? d : lm;
        mb = (w && ofs == OFS_MID_BASE) ? d : mb;
        ms = (w && ofs == OFS_MID_SIZE) ? d : ms;
        la = la | (ofs == OFS_LOWER);
        ma = ma | (ofs == OFS_MID_BASE);
        sa = sa | (ofs == OFS_MID_SIZE);
        if (!w) check("read data", 20'(rdata_q), 20'(ofs == OFS_UPPER ? um : ofs == OFS_LOWER ? lm :
            ofs == OFS_MID_BASE ? mb : ofs == OFS_MID_SIZE ? ms : 16'h0000));
    endtask

    // One bus cycle: selects one cycle later, then ready timing
    task automatic bus(input logic mem_c, input logic [19:0] a);
        logic [8:0] e;
        int         n;
        int         w;
        @(posedge clk);
        e = expect_cycle(mem_c, a);
        w = int'(e[7:6]);
        if (!e[8] && e[5:0] != 6'h3F && int'(lat) > w) w = int'(lat);
        cyc <= '{valid: 1'b1, mem: mem_c, addr: a};
        @(posedge clk);
        cyc <= '0;
        #1;
        check("selects", 20'(sel_b), 20'(e[5:0]));
        n = 0;
        while (cycle_ready_q !== 1'b1 && n < 12) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("ready cycles", 20'(n), 20'(w + 1));
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [19:0] a;
        logic [7:0]  offs [4];
        offs = '{OFS_UPPER, OFS_LOWER, OFS_MID_BASE, OFS_MID_SIZE};
        rst_b = 1'b0;
        ctl = '0;
        cyc = '0;
        lat = 4'h0;
        rnd = 32'h11;
        {um, lm, mb, ms} = {UPPER_RST, 48'h0};
        {la, ma, sa} = 3'h0;
        {mismatches, compares, cycles} = '0;
        repeat (16) @(posedge clk);
        #1;
        check("reset outputs", 20'({sel_b, cycle_ready_q}), 20'h0007E);
        @(posedge clk);
        rst_b <= 1'b1;
        reg_op(1'b0, OFS_UPPER, 16'h0000);
        bus(1'b1, 20'hFFFF0);
        bus(1'b1, 20'hFFBFF);
        bus(1'b1, 20'h00000);
        bus(1'b0, 20'hFFFF0);
        $display("test defaults done");
        // Half-megabyte mid block at zero, lower left alone
        reg_op(1'b1, OFS_MID_BASE, 16'h0005);
        bus(1'b1, 20'h10000);
        reg_op(1'b1, OFS_MID_SIZE, 16'h4000);
        for (int q = 0; q < 9; q++) bus(1'b1, 20'(q * 32'h10000));
        $display("test wide mid block done");
        reg_op(1'b1, OFS_MID_SIZE, 16'h0100);
        reg_op(1'b1, OFS_LOWER, 16'h007C);
        reg_op(1'b1, OFS_MID_BASE, 16'h4001);
        reg_op(1'b1, OFS_UPPER, 16'hFE3A);
        reg_op(1'b1, 8'hA4, 16'h1234);
        for (int i = 0; i < 5; i++) reg_op(1'b0, i < 4 ? offs[i] : 8'hA4, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            reg_op(1'b1, OFS_MID_SIZE, 16'(16'h0100 << k));
            for (int q = 0; q < 5; q++) begin
                bus(1'b1, 20'h40000 + 20'(q * (32'h800 << k)));
                bus(1'b1, 20'h3FFFF + 20'(q * (32'h800 << k)));
            end
        end
        $display("test region sizes done");
        // Random traffic with changing ready modes and device delays
        for (int i = 0; i < 300; i++) begin
            rnd = lfsr(rnd);
            if (i % 25 == 0) begin
                reg_op(1'b1, OFS_UPPER, {13'h1FC7, rnd[2:0]});
                reg_op(1'b1, OFS_LOWER, {13'h000F, rnd[5:3]});
                reg_op(1'b1, OFS_MID_BASE, {13'h0800, rnd[8:6]});
            end
            a = rnd[13:12] == 2'h0 ? 20'hFDFF8 + 20'(rnd[31:19]) : rnd[13:12] == 2'h1 ? 20'(rnd[31:20]) :
                rnd[13:12] == 2'h2 ? 20'h3E000 + 20'(rnd[31:17]) : rnd[31:12];
            @(posedge clk);
            lat <= {1'b0, rnd[11:9]};
            bus(rnd[14] | rnd[15], a);
        end
        $display("test random traffic done");
        end_sim();
    end
endmodule
